/* File: common/parallel_ports_pkg.sv */
/*
  types shared by the parallel port block.
  assumes nothing beyond a systemverilog compiler.
*/
package parallel_ports_pkg;
  // gray order along boot -> single -> expanded -> test
  typedef enum logic [1:0] {
    MODE_BOOT     = 2'b00,
    MODE_SINGLE   = 2'b01,
    MODE_EXPANDED = 2'b11,
    MODE_TEST     = 2'b10
  } op_mode_t;

  typedef logic [7:0] port_byte_t;
endpackage : parallel_ports_pkg

/* File: common/parallel_ports_regs.svh */
/*
  register offsets, bit positions, reset value and mask of the parallel port block.
  assumes a 32-bit classic wishbone slave with byte addresses; one register per aligned word.
*/
`ifndef PARALLEL_PORTS_REGS_SVH
`define PARALLEL_PORTS_REGS_SVH

// ==========================================================================
// port data and direction: address = {port index, direction bit, 2'b00}
// ==========================================================================
`define PORT_A_DATA_OFS       8'h00
`define PORT_A_DIRECTION_OFS  8'h04
`define PORT_B_DATA_OFS       8'h08
`define PORT_B_DIRECTION_OFS  8'h0C
`define PORT_C_DATA_OFS       8'h10
`define PORT_C_DIRECTION_OFS  8'h14
`define PORT_D_DATA_OFS       8'h18
`define PORT_D_DIRECTION_OFS  8'h1C
`define PORT_E_DATA_OFS       8'h20
`define PORT_F_DATA_OFS       8'h28
`define PORT_F_DIRECTION_OFS  8'h2C
`define PORT_G_DATA_OFS       8'h30
`define PORT_G_DIRECTION_OFS  8'h34
`define PORT_H_DATA_OFS       8'h38
`define PORT_H_DIRECTION_OFS  8'h3C

// ==========================================================================
// control registers
// ==========================================================================
`define SYSTEM_OPTION_TWO_OFS 8'h40
`define PULL_ASSIGNMENT_OFS   8'h44
`define PULL_CONTROL_OFS      8'h48
`define ALT_A_ENABLE_OFS      8'h4C
`define ALT_D_ENABLE_OFS      8'h50
`define ALT_H_ENABLE_OFS      8'h54

`define SYSTEM_OPTION_TWO_OPEN_DRAIN_BIT   0
`define SYSTEM_OPTION_TWO_MODE_LSB         1
`define PULL_CTL_B_BIT        0
`define PULL_CTL_F_BIT        1
`define PULL_CTL_G_BIT        2

`define PORT_RESET_VAL        8'h00
`define PORT_D_MASK           8'h3F
`define RW_STROBE_BIT         7

`endif

/* File: logic/mode_muxed_parallel_ports.sv */
/*
  mode multiplexed parallel ports a..h with a classic wishbone register slave.
  assumes pin levels are asynchronous, peripheral and bus signals are on clk_i,
  and a pad ring resolves each pin from out and active-low enable.
*/
// Behaviour
// - g7 is port i/o in single/boot, bus read/write strobe in expanded/test.
// - strobe high for a read cycle, low for a write cycle.
// - a,b,c,f,g,h eight-bit bidirectional, d six-bit, e eight-bit input only.
// - general-purpose pins that reset makes inputs are undriven after reset.
// - at reset data registers show the synchronised pin levels, as no pin is driven.
// - data reads allowed anytime: inputs give pin, outputs give driver value.
// - port a data writes do not move pins held by timer compares.
// - port a resets to high-impedance inputs; direction bits rule when alt off.
// - b,c,f,g,h writes latched; b,c,f,g7 drive only as outputs in single or boot, g6..0 and h as outputs in any mode.
// - expanded: port b drives address 15:8, port f address 7:0.
// - port c is data bus in expanded/test, gp i/o otherwise.
// - open-drain bit set: port c zero drives low, one floats.
// - port c open-drain only in single chip mode.
// - port d bits 0,1 serial one; bits 2..5 spi miso, mosi, sck, ss.
// - port d writes latched; drive pins only as gp outputs.
// - port e digital or analog inputs, never driven.
// - port g bits 6..0 stay gp i/o in every mode.
// - port h 3..0 pulse-width outputs, 5:4 serial two, 7:6 serial three.
// - port h pulls under pull assignment; 7:4 pull-ups, 3:0 pull-downs.
// - ports b, f, g have software switchable pull-ups.
// - port a alt timer: captures, compares, pulse accumulator on bit 7.
// - mode from two select inputs sampled during reset governs pins.
`include "parallel_ports_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module mode_muxed_parallel_ports #(
  parameter int BUS_DW = 32
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic [7:0]                    wb_adr_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  input  wire logic                          wb_we_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  output logic                               wb_ack_o,
  input  wire logic                          mode_select_low_i,
  input  wire logic                          mode_select_high_i,
  output parallel_ports_pkg::op_mode_t       mode_o,
  input  wire logic [15:0]                   bus_addr_i,
  input  wire logic [7:0]                    bus_wdata_i,
  input  wire logic                          bus_dir_read_i,
  output parallel_ports_pkg::port_byte_t     bus_rdata_o,
  input  wire logic [7:0]                    timer_out_i,
  input  wire logic [7:0]                    timer_oe_i,
  output parallel_ports_pkg::port_byte_t     timer_in_o,
  input  wire logic [5:0]                    serial_spi_out_i,
  input  wire logic [5:0]                    serial_spi_oe_i,
  output logic      [5:0]                    serial_spi_in_o,
  input  wire logic [7:0]                    pwm_serial_out_i,
  input  wire logic [7:0]                    pwm_serial_oe_i,
  output parallel_ports_pkg::port_byte_t     pwm_serial_in_o,
  output parallel_ports_pkg::port_byte_t     port_e_level_o,
  input  wire logic [7:0]                    port_a_in_i,
  output logic      [7:0]                    port_a_out_o,
  output logic      [7:0]                    port_a_oe_n_o,
  input  wire logic [7:0]                    port_b_in_i,
  output logic      [7:0]                    port_b_out_o,
  output logic      [7:0]                    port_b_oe_n_o,
  input  wire logic [7:0]                    port_c_in_i,
  output logic      [7:0]                    port_c_out_o,
  output logic      [7:0]                    port_c_oe_n_o,
  input  wire logic [5:0]                    port_d_in_i,
  output logic      [5:0]                    port_d_out_o,
  output logic      [5:0]                    port_d_oe_n_o,
  input  wire logic [7:0]                    port_e_in_i,
  input  wire logic [7:0]                    port_f_in_i,
  output logic      [7:0]                    port_f_out_o,
  output logic      [7:0]                    port_f_oe_n_o,
  input  wire logic [7:0]                    port_g_in_i,
  output logic      [7:0]                    port_g_out_o,
  output logic      [7:0]                    port_g_oe_n_o,
  input  wire logic [7:0]                    port_h_in_i,
  output logic      [7:0]                    port_h_out_o,
  output logic      [7:0]                    port_h_oe_n_o,
  output logic                               pull_b_en_o,
  output logic                               pull_f_en_o,
  output logic                               pull_g_en_o,
  output parallel_ports_pkg::port_byte_t     pull_h_en_o
);
  import parallel_ports_pkg::*;

  // ==========================================================================
  // elaboration checks
  // ==========================================================================
  if (BUS_DW != 32) begin : g_bad_dw
    $error("BUS_DW must be 32");
  end

  // ==========================================================================
  // state
  // ==========================================================================
  port_byte_t in_s1_q    [8];
  port_byte_t in_s2_q    [8];
  port_byte_t data_q     [8];
  port_byte_t dir_q      [8];
  port_byte_t out_d      [8];
  port_byte_t drive_d    [8];
  port_byte_t pin_out_q  [8];
  port_byte_t drive_n_q  [8];
  port_byte_t readback   [8];
  port_byte_t in_raw     [8];
  logic [1:0] mode_s1_q;
  logic [1:0] mode_s2_q;
  op_mode_t   mode_q;
  logic       od_q;
  port_byte_t pull_asg_q;
  logic [2:0] pull_ctl_q;
  port_byte_t alt_a_q;
  logic [5:0] alt_d_q;
  port_byte_t alt_h_q;
  logic       ack_q;
  logic [31:0] dat_q;

  // ==========================================================================
  // decode
  // ==========================================================================
  wire        expanded   = (mode_q == MODE_EXPANDED) || (mode_q == MODE_TEST);
  wire        single     = (mode_q == MODE_SINGLE);
  wire        od_active  = od_q & single;
  wire        wb_req     = wb_cyc_i & wb_stb_i & ~ack_q;
  wire        wb_wr      = wb_req & wb_we_i & wb_sel_i[0];
  wire        port_space = (wb_adr_i[7:6] == 2'b00);
  wire [2:0]  port_idx   = wb_adr_i[5:3];
  wire        dir_sel    = wb_adr_i[2];
  wire [7:0]  wr_byte    = wb_dat_i[7:0];

  assign in_raw[0] = port_a_in_i;
  assign in_raw[1] = port_b_in_i;
  assign in_raw[2] = port_c_in_i;
  assign in_raw[3] = {2'b00, port_d_in_i};
  assign in_raw[4] = port_e_in_i;
  assign in_raw[5] = port_f_in_i;
  assign in_raw[6] = port_g_in_i;
  assign in_raw[7] = port_h_in_i;

  // ==========================================================================
  // pin drive selection
  // ==========================================================================
  // port a: timer claims override latch and direction
  assign out_d[0]   = (alt_a_q & timer_out_i) | (~alt_a_q & data_q[0]);
  assign drive_d[0] = (alt_a_q & timer_oe_i) | (~alt_a_q & dir_q[0]);
  // port b: high address byte on the bus
  assign out_d[1]   = expanded ? bus_addr_i[15:8] : data_q[1];
  assign drive_d[1] = expanded ? 8'hFF : dir_q[1];
  // port c: data bus, driven only during bus writes
  assign out_d[2]   = expanded ? bus_wdata_i : data_q[2];
  assign drive_d[2] = expanded ? {8{~bus_dir_read_i}}
                               : (dir_q[2] & ~({8{od_active}} & data_q[2]));
  // port d: serial one on 1:0, spi on 5:2
  assign out_d[3]   = {2'b00, (alt_d_q & serial_spi_out_i) | (~alt_d_q & data_q[3][5:0])};
  assign drive_d[3] = {2'b00, (alt_d_q & serial_spi_oe_i) | (~alt_d_q & dir_q[3][5:0])};
  // port e: never driven
  assign out_d[4]   = 8'h00;
  assign drive_d[4] = 8'h00;
  // port f: low address byte on the bus
  assign out_d[5]   = expanded ? bus_addr_i[7:0] : data_q[5];
  assign drive_d[5] = expanded ? 8'hFF : dir_q[5];
  // port g: only bit 7 is taken by the bus
  assign out_d[6]   = expanded ? {bus_dir_read_i, data_q[6][6:0]} : data_q[6];
  assign drive_d[6] = expanded ? {1'b1, dir_q[6][6:0]} : dir_q[6];
  // port h: pulse width on 3:0, serial two on 5:4, serial three on 7:6
  assign out_d[7]   = (alt_h_q & pwm_serial_out_i) | (~alt_h_q & data_q[7]);
  assign drive_d[7] = (alt_h_q & pwm_serial_oe_i) | (~alt_h_q & dir_q[7]);

  // ==========================================================================
  // per-port synchroniser, latches, pins and read-back
  // ==========================================================================
  for (genvar i = 0; i < 8; i++) begin : g_port
    localparam port_byte_t MASK = (i == 3) ? `PORT_D_MASK : ((i == 4) ? 8'h00 : 8'hFF);
    wire wr_data = wb_wr & port_space & (port_idx == 3'(i)) & ~dir_sel;
    wire wr_dir  = wb_wr & port_space & (port_idx == 3'(i)) & dir_sel;

    // driver value for driven bits, else synchronised pin; in expanded mode
    // this shows the bus function rather than pin electricals
    assign readback[i] = ((drive_n_q[i] & in_s2_q[i]) | (~drive_n_q[i] & pin_out_q[i]))
                         & ((i == 3) ? `PORT_D_MASK : 8'hFF);

    always_ff @(posedge clk_i) begin
      in_s1_q[i] <= in_raw[i];
      in_s2_q[i] <= in_s1_q[i];
      if (rst_i) begin
        data_q[i]    <= `PORT_RESET_VAL;
        dir_q[i]     <= `PORT_RESET_VAL;
        pin_out_q[i] <= 8'h00;
        drive_n_q[i] <= 8'hFF;
      end else begin
        if (wr_data) begin
          data_q[i] <= wr_byte & MASK;
        end
        if (wr_dir) begin
          dir_q[i] <= wr_byte & MASK;
        end
        pin_out_q[i] <= out_d[i] & MASK;
        drive_n_q[i] <= ~(drive_d[i] & MASK);
      end
    end
  end

  // ==========================================================================
  // mode capture
  // ==========================================================================
  // the mode is held from reset release; later pin changes are ignored
  always_ff @(posedge clk_i) begin
    mode_s1_q <= {mode_select_high_i, mode_select_low_i};
    mode_s2_q <= mode_s1_q;
    if (rst_i) begin
      mode_q <= op_mode_t'(mode_s2_q);
    end
  end

  // ==========================================================================
  // wishbone slave, one wait state, unmapped reads give zero
  // ==========================================================================
  wire [31:0] rd_word =
      port_space                              ? {24'h0, dir_sel ? dir_q[port_idx] : readback[port_idx]} :
      (wb_adr_i == `SYSTEM_OPTION_TWO_OFS)    ? {29'h0, mode_q, od_q} :
      (wb_adr_i == `PULL_ASSIGNMENT_OFS)      ? {24'h0, pull_asg_q} :
      (wb_adr_i == `PULL_CONTROL_OFS)         ? {29'h0, pull_ctl_q} :
      (wb_adr_i == `ALT_A_ENABLE_OFS)         ? {24'h0, alt_a_q} :
      (wb_adr_i == `ALT_D_ENABLE_OFS)         ? {26'h0, alt_d_q} :
      (wb_adr_i == `ALT_H_ENABLE_OFS)         ? {24'h0, alt_h_q} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q      <= 1'b0;
      dat_q      <= 32'h0;
      od_q       <= 1'b0;
      pull_asg_q <= 8'h00;
      pull_ctl_q <= 3'h0;
      alt_a_q    <= 8'h00;
      alt_d_q    <= 6'h00;
      alt_h_q    <= 8'h00;
    end else begin
      ack_q <= wb_req;
      dat_q <= wb_req ? rd_word : 32'h0;
      if (wb_wr && wb_adr_i == `SYSTEM_OPTION_TWO_OFS) begin
        od_q <= wr_byte[`SYSTEM_OPTION_TWO_OPEN_DRAIN_BIT];
      end
      if (wb_wr && wb_adr_i == `PULL_ASSIGNMENT_OFS) begin
        pull_asg_q <= wr_byte;
      end
      if (wb_wr && wb_adr_i == `PULL_CONTROL_OFS) begin
        pull_ctl_q <= wr_byte[2:0];
      end
      if (wb_wr && wb_adr_i == `ALT_A_ENABLE_OFS) begin
        alt_a_q <= wr_byte;
      end
      if (wb_wr && wb_adr_i == `ALT_D_ENABLE_OFS) begin
        alt_d_q <= wr_byte[5:0];
      end
      if (wb_wr && wb_adr_i == `ALT_H_ENABLE_OFS) begin
        alt_h_q <= wr_byte;
      end
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign wb_ack_o        = ack_q;
  assign wb_dat_o        = dat_q;
  assign mode_o          = mode_q;
  assign bus_rdata_o     = in_s2_q[2];
  assign timer_in_o      = in_s2_q[0];
  assign serial_spi_in_o = in_s2_q[3][5:0];
  assign pwm_serial_in_o = in_s2_q[7];
  assign port_e_level_o  = in_s2_q[4];
  assign port_a_out_o    = pin_out_q[0];
  assign port_a_oe_n_o   = drive_n_q[0];
  assign port_b_out_o    = pin_out_q[1];
  assign port_b_oe_n_o   = drive_n_q[1];
  assign port_c_out_o    = pin_out_q[2];
  assign port_c_oe_n_o   = drive_n_q[2];
  assign port_d_out_o    = pin_out_q[3][5:0];
  assign port_d_oe_n_o   = drive_n_q[3][5:0];
  assign port_f_out_o    = pin_out_q[5];
  assign port_f_oe_n_o   = drive_n_q[5];
  assign port_g_out_o    = pin_out_q[6];
  assign port_g_oe_n_o   = drive_n_q[6];
  assign port_h_out_o    = pin_out_q[7];
  assign port_h_oe_n_o   = drive_n_q[7];
  assign pull_b_en_o     = pull_ctl_q[`PULL_CTL_B_BIT];
  assign pull_f_en_o     = pull_ctl_q[`PULL_CTL_F_BIT];
  assign pull_g_en_o     = pull_ctl_q[`PULL_CTL_G_BIT];
  assign pull_h_en_o     = pull_asg_q;

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_rw_strobe;
    expanded |=> (!port_g_oe_n_o[7] && port_g_out_o[7] == $past(bus_dir_read_i));
  endproperty
  a_rw_strobe: assert property (p_rw_strobe) else $error("g7 not the bus strobe");

  property p_addr_out;
    expanded |=> (port_b_out_o == $past(bus_addr_i[15:8]) && port_f_out_o == $past(bus_addr_i[7:0])
                  && port_b_oe_n_o == 8'h00 && port_f_oe_n_o == 8'h00);
  endproperty
  a_addr_out: assert property (p_addr_out) else $error("address ports wrong");

  property p_data_bus;
    (expanded && !bus_dir_read_i) |=> (port_c_oe_n_o == 8'h00 && port_c_out_o == $past(bus_wdata_i));
  endproperty
  a_data_bus: assert property (p_data_bus) else $error("port c not driving write data");

  property p_open_drain;
    (single && od_q && !expanded) |=> ((port_c_oe_n_o | ~$past(data_q[2])) == 8'hFF);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain one driven");

  property p_gp_release;
    $fell(rst_i) |-> (port_a_oe_n_o == 8'hFF && port_h_oe_n_o == 8'hFF && port_d_oe_n_o == 6'h3F);
  endproperty
  a_gp_release: assert property (@(posedge clk_i) p_gp_release) else $error("pin driven after reset");

  property p_timer_owns;
    (alt_a_q == 8'hFF && wb_wr && port_space && port_idx == 3'd0 && !dir_sel)
      |=> port_a_out_o == $past(timer_out_i);
  endproperty
  a_timer_owns: assert property (p_timer_owns) else $error("port a write moved timer pin");

  property p_port_e_read;
    (wb_req && !wb_we_i && wb_adr_i == `PORT_E_DATA_OFS) |=> wb_dat_o[7:0] == $past(port_e_in_i, 3);
  endproperty
  a_port_e_read: assert property (p_port_e_read) else $error("port e read not the pin level");

  property p_mode_hold;
    !$past(rst_i) |-> $stable(mode_q);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed outside reset");

  property p_pd_latch;
    (alt_d_q == 6'h00 && dir_q[3][5:0] == 6'h3F) |=> port_d_out_o == $past(data_q[3][5:0]);
  endproperty
  a_pd_latch: assert property (p_pd_latch) else $error("port d latch not driven");

  c_expanded_write: cover property (expanded && !bus_dir_read_i);
  c_open_drain:     cover property (od_active && dir_q[2] != 8'h00);
  c_timer_alt:      cover property (alt_a_q != 8'h00 && timer_oe_i != 8'h00);
  c_wb_read:        cover property (wb_ack_o && !wb_we_i);

endmodule : mode_muxed_parallel_ports

`default_nettype wire

/* File: tb/mode_muxed_parallel_ports_tb.sv */
/*
  self-checking bench for the mode multiplexed ports.
  assumes the package, register header and pin board model are compiled first.
*/
`include "parallel_ports_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module mode_muxed_parallel_ports_tb;
  import parallel_ports_pkg::*;
  logic clk = 0, rst = 1, ml = 1, mh = 0, we = 0, cyc = 0, stb = 0, rd = 0, hold = 0;
  logic [7:0] adr = 0, tme = 0, tmo = 0, wd = 0, pe = 0, d, m, v;
  logic [31:0] dat = 0, r;
  logic [15:0] ba = 0;
  logic [5:0] so = 0, soe = 0;
  logic [7:0] po = 0, poe = 0;
  logic [55:0] ext = 0;
  wire logic [55:0] dout, doe, pin;
  wire logic [31:0] rdat;
  wire logic ack, pb, pf, pg;
  wire logic [7:0] ph;
  wire logic [7:0] brd, tin, pwi, pel;
  wire logic [5:0] sin;
  op_mode_t mode;
  int err_total = 0, n_checks = 0, seed = 32'hd1204450;
  logic [7:0] ofs [7] = '{8'h38, 8'h30, 8'h28, 8'h18, 8'h10, 8'h08, 8'h00};
  assign dout[31:30] = 2'b00;
  assign doe[31:30] = 2'b11;
  always #50 clk = ~clk;
  always @(posedge clk) if (!hold) {so, soe, po, poe} <= 28'($random(seed));
  mode_muxed_parallel_ports u_dut (.clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .mode_select_low_i(ml),
    .mode_select_high_i(mh), .mode_o(mode), .bus_addr_i(ba), .bus_wdata_i(wd), .bus_dir_read_i(rd),
    .bus_rdata_o(brd), .timer_out_i(tmo), .timer_oe_i(tme), .timer_in_o(tin), .serial_spi_out_i(so),
    .serial_spi_oe_i(soe), .serial_spi_in_o(sin), .pwm_serial_out_i(po), .pwm_serial_oe_i(poe),
    .pwm_serial_in_o(pwi), .port_e_level_o(pel), .port_a_in_i(pin[55:48]), .port_a_out_o(dout[55:48]),
    .port_a_oe_n_o(doe[55:48]), .port_b_in_i(pin[47:40]), .port_b_out_o(dout[47:40]), .port_b_oe_n_o(doe[47:40]),
    .port_c_in_i(pin[39:32]), .port_c_out_o(dout[39:32]), .port_c_oe_n_o(doe[39:32]), .port_d_in_i(pin[29:24]),
    .port_d_out_o(dout[29:24]), .port_d_oe_n_o(doe[29:24]), .port_e_in_i(pe), .port_f_in_i(pin[23:16]),
    .port_f_out_o(dout[23:16]), .port_f_oe_n_o(doe[23:16]), .port_g_in_i(pin[15:8]), .port_g_out_o(dout[15:8]),
    .port_g_oe_n_o(doe[15:8]), .port_h_in_i(pin[7:0]), .port_h_out_o(dout[7:0]), .port_h_oe_n_o(doe[7:0]),
    .pull_b_en_o(pb), .pull_f_en_o(pf), .pull_g_en_o(pg), .pull_h_en_o(ph));
  pin_board_model #(.W(56)) u_board (.clk_i(clk), .out_i(dout), .oe_n_i(doe), .ext_i(ext),
    .ext_en_i({56{1'b1}}), .pin_o(pin));
  // ========
  // helpers
  function automatic logic [7:0] gp(input logic [7:0] dir, dv, pv);
    return (dv & dir) | (pv & ~dir);
  endfunction : gp
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, x};
    // no local limit: only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic go(input op_mode_t md);
    @(posedge clk);
    {mh, ml} <= md;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(mode, md);
  endtask : go
  task automatic od(input op_mode_t md, input logic on);
    go(md);
    d = 8'($random(seed));
    wb(1, `SYSTEM_OPTION_TWO_OFS, 8'h01);
    wb(1, `PORT_C_DIRECTION_OFS, 8'hFF);
    wb(1, `PORT_C_DATA_OFS, d);
    wb(1, `PORT_G_DIRECTION_OFS, 8'h80);
    wb(1, `PORT_G_DATA_OFS, 8'h80);
    repeat (2) @(posedge clk);
    chk(doe[39:32], on ? d : 8'h00);
    chk(dout[39:32] & ~d, 8'h00);
    chk({doe[15], dout[15]}, 2'b01);
    $display("open drain test done");
  endtask : od
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  // ========
  // tests
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    test_done();
  end
  initial begin
    go(MODE_SINGLE);
    chk(doe[55:24], 32'hFFFF_FFFF);
    chk(doe[23:0], 32'h00FF_FFFF);
    for (int k = 0; k < 7; k++) begin
      for (int j = 0; j < 4; j++) begin
        m = (k == 3) ? 8'h3F : 8'hFF;
        v = (j == 0) ? 8'hFF : (j == 1) ? 8'h00 : 8'($random(seed));
        d = (j == 0) ? 8'h55 : 8'($random(seed));
        ext[k*8+:8] <= 8'($random(seed));
        wb(1, ofs[k] + 8'h04, v);
        wb(1, ofs[k], d);
        repeat (4) @(posedge clk);
        wb(0, ofs[k], 8'h00);
        chk({r[31:8], r[7:0] & m}, {24'h0, gp(v, d, ext[k*8+:8]) & m});
        chk(doe[k*8+:8] | ~m, ~(v & m));
        chk(dout[k*8+:8] & v & m, d & v & m);
      end
    end
    $display("port test done");
    pe <= 8'($random(seed));
    repeat (4) @(posedge clk);
    wb(1, `PORT_E_DATA_OFS, ~pe);
    wb(0, `PORT_E_DATA_OFS, 8'h00);
    chk(r, {24'h0, pe});
    chk(pel, pe);
    wb(0, 8'h24, 8'h00);
    chk(r, 32'h0);
    wb(0, 8'h80, 8'h00);
    chk(r, 32'h0);
    for (int j = 0; j < 8; j++) begin
      v = 8'($random(seed));
      wb(1, `PULL_CONTROL_OFS, v);
      wb(1, `PULL_ASSIGNMENT_OFS, ~v);
      @(posedge clk);
      chk({pg, pf, pb}, v[2:0]);
      chk(ph, 8'(~v));
    end
    tme <= 8'hFF;
    tmo <= 8'($random(seed));
    wb(1, `ALT_A_ENABLE_OFS, 8'hFF);
    wb(1, `PORT_A_DATA_OFS, ~tmo);
    repeat (2) @(posedge clk);
    chk(dout[55:48], tmo);
    chk(doe[55:48], 8'h00);
    chk(tin, tmo);
    tme <= 8'h00;
    repeat (2) @(posedge clk);
    chk(doe[55:48], 8'hFF);
    // freeze the peripheral drive so the pins can be predicted
    hold <= 1'b1;
    wb(1, `ALT_D_ENABLE_OFS, 8'h3F);
    wb(1, `ALT_H_ENABLE_OFS, 8'hFF);
    repeat (4) @(posedge clk);
    chk({doe[29:24], doe[7:0]}, 14'(~{soe, poe}));
    chk({dout[29:24], dout[7:0]}, {so, po});
    chk(sin, (so & soe) | (ext[29:24] & ~soe));
    chk(pwi, (po & poe) | (ext[7:0] & ~poe));
    hold <= 1'b0;
    $display("pull and timer test done");
    od(MODE_SINGLE, 1'b1);
    od(MODE_BOOT, 1'b0);
    go(MODE_EXPANDED);
    d = 8'($random(seed));
    wb(1, `PORT_G_DIRECTION_OFS, 8'h7F);
    wb(1, `PORT_G_DATA_OFS, d);
    for (int j = 0; j < 6; j++) begin
      ba <= 16'($random(seed));
      wd <= 8'($random(seed));
      rd <= j[0];
      // two extra edges let the pin pass the input synchroniser
      repeat (4) @(posedge clk);
      chk(brd, rd ? ext[39:32] : wd);
      chk({dout[47:40], dout[23:16]}, ba);
      chk({doe[47:40], doe[23:16]}, 16'h0);
      chk({doe[15:8], dout[15:8]}, {9'h0, rd, d[6:0]});
      chk(doe[39:32], rd ? 8'hFF : 8'h00);
      chk(dout[39:32] | {8{rd}}, rd ? 8'hFF : wd);
    end
    $display("expanded test done");
    test_done();
  end
endmodule : mode_muxed_parallel_ports_tb
`default_nettype wire

/* File: tb/pin_board_model.sv */
/*
  board-side pin model: resolves each pad from device drive and board drive.
  assumes active-low device enables and one clock for the hold memory.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_board_model #(
  parameter int W = 56
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] out_i,
  input  wire logic [W-1:0] oe_n_i,
  input  wire logic [W-1:0] ext_i,
  input  wire logic [W-1:0] ext_en_i,
  output logic      [W-1:0] pin_o
);
  logic [W-1:0] last_q;
  // a released line flips each cycle, so a stale level never reads back as good
  always_comb pin_o = (~oe_n_i & out_i) | (oe_n_i & ext_en_i & ext_i) | (oe_n_i & ~ext_en_i & ~last_q);
  always_ff @(posedge clk_i) last_q <= pin_o;
endmodule : pin_board_model
`default_nettype wire
